// ### hw/queue_route_pkg.sv
package queue_route_pkg;
  localparam logic [8:0] route_upper_low_half_addr = 9'h17c;
  localparam int route_width = 16;
  localparam logic [15:0] route_reset = 16'h0000;
  localparam logic [5:0] first_queue = 6'h10;
  localparam logic [5:0] last_queue = 6'h1f;
  localparam int queue_count = 64;
  localparam int queues_per_group = 4;
  localparam int group_count = 16;
  localparam int sixteen_port_queue_limit = 32;
endpackage : queue_route_pkg

// ### hw/egress_queue_port_routing.sv
// Summary of operation
// R1: Bit 0 routes queue 16, up to bit 15 routing queue 31.
// R2: Sixty-four queues form sixteen groups of four consecutive queues.
// R3: Group g serves ports 2g and 2g+1 outside the special case.
// R4: Routing bit zero sends the queue to the group's even port.
// R5: Routing bit one sends the queue to the group's odd port.
// R6: Eight even ports only: software writes all zeros.
// R7: Normal 32-port mode: software writes the alternating pattern.
// R8: Sixteen-port select set: register ignored, port n owns group n.
// R9: Sixteen ports, select clear: only queues 0-31, shared by routing bits.
// R10: Normal 16-port, select clear: software writes the alternating pattern.
// R11: New routing applies only to cells started after the write.
`timescale 1ns/10ps
`default_nettype none
module egress_queue_port_routing
  import queue_route_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // Register port
  input wire logic [8:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  // Mode
  input wire logic i_multi_phy_operation_sixteen,
  input wire logic i_sixteen_port_full_group_select,
  // Scheduler lookup
  input wire logic i_cell_start,
  input wire logic [5:0] i_queue,
  output logic [4:0] o_phy_port,
  output logic o_queue_valid
);
  import queue_route_pkg::*;

  // Whole state of the block, registered as one word
  typedef struct packed {
    logic [15:0] queue_route_upper_low_half;
    logic [15:0] rdata;
    logic [4:0] port;
    logic valid;
  } state_s;

  // How ports own queues
  typedef enum logic [2:0] {
    mode_pair_wide = 3'b001,
    mode_pair_sixteen = 3'b010,
    mode_full_sixteen = 3'b100
  } route_mode_e;

  // Current and next state
  state_s r;
  state_s next_r;

  // Only one word of the map belongs to this block
  function automatic logic addr_hit(input logic [8:0] addr);
    if (addr == route_upper_low_half_addr) begin
      addr_hit = 1'b1;
    end else begin
      addr_hit = 1'b0;
    end
  endfunction : addr_hit

  // Writes elsewhere in the map leave the word alone
  function automatic logic [15:0] merge_write(
    input logic [15:0] old_value,
    input logic wr,
    input logic [8:0] addr,
    input logic [15:0] wdata
  );
    if (wr && addr_hit(addr)) begin
      merge_write = wdata;
    end else begin
      merge_write = old_value;
    end
  endfunction : merge_write

  // Unmapped addresses read as zero
  function automatic logic [15:0] read_value(
    input logic [8:0] addr,
    input logic [15:0] value
  );
    if (addr_hit(addr)) begin
      read_value = value;
    end else begin
      read_value = 16'h0000;
    end
  endfunction : read_value

  // Queues routed by this word
  function automatic logic in_window(input logic [5:0] q);
    logic above_low;
    logic below_high;
    above_low = (q >= first_queue);
    below_high = (q <= last_queue);
    in_window = above_low && below_high;
  endfunction : in_window

  // Four consecutive queues per group [R2]
  function automatic logic [3:0] group_of(input logic [5:0] q);
    group_of = q[5:2];
  endfunction : group_of

  // Bit 0 of the word is the first queue of the window [R1]
  function automatic logic [3:0] route_index(input logic [5:0] q);
    logic [5:0] offset;
    offset = q - first_queue;
    route_index = offset[3:0];
  endfunction : route_index

  // Routing bit of one queue
  function automatic logic route_bit(
    input logic [15:0] word,
    input logic [3:0] idx
  );
    route_bit = word[idx];
  endfunction : route_bit

  // Select bit only counts in sixteen-port operation
  function automatic route_mode_e decode_mode(
    input logic sixteen,
    input logic sel
  );
    if (!sixteen) begin
      decode_mode = mode_pair_wide;
    end else if (sel) begin
      decode_mode = mode_full_sixteen;
    end else begin
      decode_mode = mode_pair_sixteen;
    end
  endfunction : decode_mode

  // Cleared bit picks the even port, set bit the odd port [R3] [R4] [R5]
  function automatic logic [4:0] pair_port(
    input logic [3:0] grp,
    input logic odd
  );
    pair_port = {grp, odd};
  endfunction : pair_port

  // Port n owns group n outright [R8]
  function automatic logic [4:0] full_port(input logic [3:0] grp);
    full_port = {1'b0, grp};
  endfunction : full_port

  // Shared groups in sixteen-port operation stop at the limit [R9]
  function automatic logic covered(
    input logic [5:0] q,
    input logic sixteen
  );
    logic below_limit;
    below_limit = (q < 6'(sixteen_port_queue_limit));
    if (sixteen) begin
      covered = in_window(q) && below_limit;
    end else begin
      covered = in_window(q);
    end
  endfunction : covered

  // Next state
  always_comb begin
    logic [3:0] grp;
    logic [3:0] bit_idx;
    logic odd;
    route_mode_e mode;

    grp = 4'h0;
    bit_idx = 4'h0;
    odd = 1'b0;
    mode = mode_pair_wide;
    next_r = r;

    // Register write, one word
    next_r.queue_route_upper_low_half = merge_write(r.queue_route_upper_low_half,
                                                    i_reg_wr, i_reg_addr, i_reg_wdata);

    // Read data trails the address by one cycle
    next_r.rdata = read_value(i_reg_addr, r.queue_route_upper_low_half);

    // Old word used at cell start: a same-cycle write waits for the next cell [R11]
    if (i_cell_start) begin
      grp = group_of(i_queue); // [R2]
      bit_idx = route_index(i_queue); // [R1]
      odd = route_bit(r.queue_route_upper_low_half, bit_idx);
      mode = decode_mode(i_multi_phy_operation_sixteen, i_sixteen_port_full_group_select);
      // Port choice by ownership mode
      unique case (mode)
        mode_full_sixteen: begin
          next_r.port = full_port(grp); // [R8]
          next_r.valid = 1'b1;
        end
        mode_pair_sixteen: begin
          next_r.port = pair_port(grp, odd); // [R3] [R4] [R5]
          next_r.valid = covered(i_queue, 1'b1); // [R9]
        end
        mode_pair_wide: begin
          next_r.port = pair_port(grp, odd); // [R3] [R4] [R5]
          next_r.valid = covered(i_queue, 1'b0);
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      // Fields cleared one by one on reset
      r.queue_route_upper_low_half <= route_reset;
      r.rdata <= 16'h0000;
      r.port <= 5'h00;
      r.valid <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from the state flops
  assign o_reg_rdata = r.rdata;
  assign o_phy_port = r.port;
  assign o_queue_valid = r.valid;
endmodule : egress_queue_port_routing
`default_nettype wire

// ### tb/egress_queue_port_routing_chk.sv
`timescale 1ns/10ps
`default_nettype none
module egress_route_chk (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic [8:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic [15:0] o_reg_rdata,
  input wire logic i_cell_start,
  input wire logic [5:0] i_queue,
  input wire logic i_multi_phy_operation_sixteen,
  input wire logic i_sixteen_port_full_group_select,
  input wire logic [4:0] o_phy_port,
  input wire logic o_queue_valid
);
default clocking @(posedge i_sys_clk); endclocking
default disable iff (!i_rstn);
logic [15:0] shadow;
logic pair_mode;
logic in_range;
assign pair_mode = !(i_multi_phy_operation_sixteen && i_sixteen_port_full_group_select);
assign in_range = (i_queue >= 6'h10) && (i_queue <= 6'h1f);
// Expected routing word, kept from the bus alone
always_ff @(posedge i_sys_clk or negedge i_rstn) begin
  if (!i_rstn) begin
    shadow <= 16'h0000;
  end else if (i_reg_wr && (i_reg_addr == 9'h17c)) begin
    shadow <= i_reg_wdata;
  end
end
sequence s_route_write;
  i_reg_wr && (i_reg_addr == 9'h17c);
endsequence
sequence s_route_read;
  !i_reg_wr && (i_reg_addr == 9'h17c);
endsequence
sequence s_pair_start;
  i_cell_start && pair_mode && in_range;
endsequence
AST_GROUP: assert property (i_cell_start && !i_sixteen_port_full_group_select |=>
!o_queue_valid || o_phy_port[4:1]==$past(i_queue[5:2])) else $error("group port wrong");
AST_FULL: assert property (i_cell_start && i_multi_phy_operation_sixteen
&& i_sixteen_port_full_group_select |=> o_queue_valid && o_phy_port==$past(i_queue[5:2]))
else $error("full group port wrong");
AST_RANGE: assert property (i_cell_start && pair_mode && !in_range |=> !o_queue_valid)
else $error("uncovered queue marked valid");
AST_EVEN: assert property ((s_pair_start ##0 !shadow[i_queue[3:0]]) |=>
o_queue_valid && !o_phy_port[0]) else $error("even port not chosen");
AST_ODD: assert property ((s_pair_start ##0 shadow[i_queue[3:0]]) |=>
o_queue_valid && o_phy_port[0]) else $error("odd port not chosen");
AST_HOLD: assert property (!i_cell_start |=> $stable(o_phy_port) && $stable(o_queue_valid))
else $error("route changed without cell start");
AST_WRITE: assert property (s_route_write ##1 s_route_read |=>
o_reg_rdata == $past(i_reg_wdata, 2)) else $error("routing word readback wrong");
endmodule : egress_route_chk
bind egress_queue_port_routing egress_route_chk chk(.*);
`default_nettype wire

// ### tb/egress_queue_port_routing_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module egress_queue_port_routing_tb_top;
logic c=0,r=0,w=0,s=0,m=0,f=0,v;
logic [8:0] a=9'h17c;logic [15:0] d=16'h0,rd;logic [5:0] q=6'h0;logic [4:0] p;
int err_count=0,comparisons=0;
egress_queue_port_routing dut(.i_sys_clk(c),.i_rstn(r),.i_reg_addr(a),.i_reg_wr(w),
.i_reg_wdata(d),.o_reg_rdata(rd),.i_multi_phy_operation_sixteen(m),
.i_sixteen_port_full_group_select(f),.i_cell_start(s),.i_queue(q),.o_phy_port(p),
.o_queue_valid(v));
initial forever #20 c=~c;
task cmp(input logic [15:0] g,input logic [15:0] e);
comparisons++;
if(g!==e) begin
err_count++;
$display("mismatch %0t %h %h",$time,g,e);
end
endtask : cmp
task wr(input logic [15:0] x);
@(posedge c) #1 w=1; d=x;
@(posedge c) #1 w=0;
endtask : wr
task lk(input logic [5:0] x,input logic [5:0] e);
@(posedge c) #1 s=1; q=x;
@(posedge c) #1 s=0;
cmp({10'h0,p,v},{10'h0,e});
endtask : lk
task end_sim;
$display("errors %0d comparisons %0d",err_count,comparisons);
if(err_count==0&&comparisons>0) $display("bench passed");
else $display("bench failed");
$finish;
endtask : end_sim
initial begin
repeat(20) @(posedge c);
#1 r=1;
cmp(rd,16'h0);
wr(16'haaaa);
@(posedge c) #1 cmp(rd,16'haaaa);
lk(6'h10,6'h11);
lk(6'h11,6'h13);
lk(6'h1f,6'h1f);
wr(16'h0);
lk(6'h13,6'h11);
m=1;
wr(16'haaaa);
lk(6'h11,6'h13);
@(posedge c) #1 s=1; q=6'h20;
@(posedge c) #1 s=0;
cmp({15'h0,v},16'h0);
a=9'h17e;
@(posedge c) #1 cmp(rd,16'h0);
a=9'h17c;
f=1;
lk(6'h05,6'h03);
end_sim;
end
initial begin
#100000;
err_count++;
end_sim;
end
endmodule : egress_queue_port_routing_tb_top
`default_nettype wire
